// [rtl/filter_setup_pkg.sv]
`default_nettype none
package filter_setup_pkg;
    // ----------------------------------------------------------------
    // Register map (indices, byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int NUM_SETUPS = 2;
    localparam logic [9:0] FILTER_CONFIG_SETUP2_IDX = 10'h02a;
    localparam logic [9:0] FILTER_CONFIG_SETUP3_IDX = 10'h02b;
    localparam logic [ADDR_W-1:0] FILTER_CONFIG_SETUP2_ADDR = {FILTER_CONFIG_SETUP2_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] FILTER_CONFIG_SETUP3_ADDR = {FILTER_CONFIG_SETUP3_IDX, 2'b00};
    localparam logic [15:0] FILTER_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] FILTER_CONFIG_WRITE_MASK = 16'h8f7f;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int MAP_BIT = 15;
    localparam int DECIM_HI = 14;
    localparam int POST_EN_BIT = 11;
    localparam int POST_SEL_HI = 10;
    localparam int POST_SEL_LO = 8;
    localparam int ORDER_HI = 6;
    localparam int ORDER_LO = 5;
    localparam int RATE_HI = 4;

    // ----------------------------------------------------------------
    // Encodings and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] ORDER_SINC5_SINC1 = 2'h0;
    localparam logic [1:0] ORDER_SINC3 = 2'h3;
    localparam logic [4:0] RATE_CODE_FASTEST = 5'h00;
    localparam logic [4:0] RATE_CODE_SLOWEST = 5'h14;
    localparam logic [2:0] POST_27_SPS = 3'h2;
    localparam logic [2:0] POST_25_SPS = 3'h3;
    localparam logic [2:0] POST_20_SPS = 3'h5;
    localparam logic [2:0] POST_16_67_SPS = 3'h6;
    localparam int DECIM_SHIFT = 5;
    localparam int PERIOD_W = 20;

    function automatic logic post_code_listed(input logic [2:0] code);
        post_code_listed = (code == POST_27_SPS) || (code == POST_25_SPS) ||
                           (code == POST_20_SPS) || (code == POST_16_67_SPS);
    endfunction
endpackage
`default_nettype wire

// [rtl/setup_cfg_if.sv]
`default_nettype none
interface setup_cfg_if;
    logic direct_map;
    logic [14:0] decimation;
    logic order_sinc3;
    logic [4:0] rate_code;
    logic rate_valid;
    logic post_active;
    logic [2:0] post_code;
    logic result_strobe;

    modport decoder (output direct_map, decimation, order_sinc3, rate_code, rate_valid,
                     post_active, post_code);
    modport pacer (input direct_map, decimation, output result_strobe);
endinterface
`default_nettype wire

// [rtl/setup_decode.sv]
`default_nettype none
module setup_decode
    import filter_setup_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [15:0] cfg_i,
    setup_cfg_if.decoder cfg_o
);
    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    logic map_next;
    logic [1:0] order_next;
    assign map_next = cfg_i[MAP_BIT];
    assign order_next = cfg_i[ORDER_HI:ORDER_LO];

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_o.direct_map <= 1'b0;
            cfg_o.decimation <= 15'h0000;
            cfg_o.order_sinc3 <= 1'b0;
            cfg_o.rate_code <= 5'h00;
            cfg_o.rate_valid <= 1'b0;
            cfg_o.post_active <= 1'b0;
            cfg_o.post_code <= 3'h0;
        end else begin
            cfg_o.direct_map <= map_next; // [RQ4]
            cfg_o.decimation <= map_next ? cfg_i[DECIM_HI:0] : 15'h0000; // [RQ5]
            cfg_o.order_sinc3 <= map_next || (order_next == ORDER_SINC3); // [RQ3]
            cfg_o.rate_code <= map_next ? RATE_CODE_FASTEST : cfg_i[RATE_HI:0]; // [RQ1]
            cfg_o.rate_valid <= !map_next && (cfg_i[RATE_HI:0] <= RATE_CODE_SLOWEST); // [RQ1]
            cfg_o.post_active <= !map_next && cfg_i[POST_EN_BIT] &&
                                 (order_next == ORDER_SINC5_SINC1) &&
                                 post_code_listed(cfg_i[POST_SEL_HI:POST_SEL_LO]); // [RQ7]
            cfg_o.post_code <= map_next ? 3'h0 : cfg_i[POST_SEL_HI:POST_SEL_LO]; // [RQ8]
        end
    end
endmodule
`default_nettype wire

// [rtl/decimation_pacer.sv]
`default_nettype none
module decimation_pacer
    import filter_setup_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic modulator_tick_i,
    setup_cfg_if.pacer cfg
);
    // ----------------------------------------------------------------
    // Result pacing in direct decimation mode
    // ----------------------------------------------------------------
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] count_reg;
    logic running;
    assign period = {cfg.decimation, 5'h00};
    assign running = cfg.direct_map && (cfg.decimation != 15'h0000);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_reg <= 20'h00000;
            cfg.result_strobe <= 1'b0;
        end else if (!running) begin
            count_reg <= 20'h00000;
            cfg.result_strobe <= 1'b0;
        end else if (modulator_tick_i) begin
            if (count_reg >= period - 20'h00001) begin // [RQ5]
                count_reg <= 20'h00000;
                cfg.result_strobe <= 1'b1;
            end else begin
                count_reg <= count_reg + 20'h00001;
                cfg.result_strobe <= 1'b0;
            end
        end else begin
            cfg.result_strobe <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [PERIOD_W-1:0] ticks_seen;
    logic clean_run;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ticks_seen <= 20'h00000;
            clean_run <= 1'b0;
        end else if (!running || $changed(cfg.decimation)) begin
            ticks_seen <= 20'h00000;
            clean_run <= 1'b0;
        end else if (cfg.result_strobe) begin
            ticks_seen <= {19'h00000, modulator_tick_i};
            clean_run <= 1'b1;
        end else if (modulator_tick_i) begin
            ticks_seen <= ticks_seen + 20'h00001;
        end
    end

    a_decimation_period: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ5]
        cfg.result_strobe && clean_run && $stable(cfg.decimation) |-> ticks_seen == period)
        else $error("result spacing differs from 32 times decimation");
endmodule
`default_nettype wire

// [rtl/filter_setup_config_regs.sv]
`default_nettype none
// Overview of operation
// [RQ1] Setup 2 rate field selects output rate
// [RQ2] Sinc3 needs same order, rate everywhere (not checked; each setup decodes its own order and rate)
// [RQ3] Order code 00 is sinc5+sinc1, default
// [RQ4] Bit 15 set: direct sinc3 decimation only
// [RQ5] Results every 32 times decimation modulator clocks
// [RQ6] Reserved bits written zero, read zero
// [RQ7] Post filter enable needs sinc5+sinc1 order
// [RQ8] Three-bit code selects post filter rate
// [RQ9] Setup 3 register resets to zero
// [RQ10] Only listed post filter codes used
module filter_setup_config_regs
    import filter_setup_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic modulator_tick_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [NUM_SETUPS-1:0] direct_map_o,
    output logic [NUM_SETUPS-1:0][14:0] decimation_o,
    output logic [NUM_SETUPS-1:0] order_sinc3_o,
    output logic [NUM_SETUPS-1:0][4:0] rate_code_o,
    output logic [NUM_SETUPS-1:0] rate_valid_o,
    output logic [NUM_SETUPS-1:0] post_active_o,
    output logic [NUM_SETUPS-1:0][2:0] post_code_o,
    output logic [NUM_SETUPS-1:0] result_strobe_o
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_ANSWER} apb_state_e;

    // Returns {hit, index}; index 0 is setup 2, index 1 is setup 3
    function automatic logic [1:0] decode_addr(input logic [ADDR_W-1:0] addr);
        if (addr == FILTER_CONFIG_SETUP2_ADDR) begin
            decode_addr = 2'b10;
        end else if (addr == FILTER_CONFIG_SETUP3_ADDR) begin
            decode_addr = 2'b11;
        end else begin
            decode_addr = 2'b00;
        end
    endfunction

    function automatic logic [15:0] merge_write(input logic [15:0] old_val,
                                                input logic [15:0] wdata,
                                                input logic [1:0] strb);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}};
        merge_write = ((old_val & ~lanes) | (wdata & lanes)) & FILTER_CONFIG_WRITE_MASK;
    endfunction

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    apb_state_e state_reg;
    logic [15:0] cfg_reg [NUM_SETUPS];
    logic [1:0] req_dec;
    logic access;
    logic commit;
    assign req_dec = decode_addr(paddr_i);
    assign access = psel_i && penable_i;
    assign commit = access && pready_o;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            pready_o <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (access) begin
                        state_reg <= ST_ANSWER;
                        pready_o <= 1'b1;
                    end
                end
                ST_ANSWER: begin
                    state_reg <= ST_IDLE;
                    pready_o <= 1'b0;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    pready_o <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else if (state_reg == ST_IDLE && access) begin
            pslverr_o <= !req_dec[1];
            if (!pwrite_i && req_dec[1]) begin
                prdata_o <= {16'h0000, cfg_reg[req_dec[0]]}; // [RQ6]
            end else begin
                prdata_o <= 32'h00000000;
            end
        end else if (commit) begin
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_SETUPS; i++) begin
                cfg_reg[i] <= FILTER_CONFIG_RESET; // [RQ9]
            end
        end else if (commit && pwrite_i && req_dec[1]) begin
            cfg_reg[req_dec[0]] <= merge_write(cfg_reg[req_dec[0]], pwdata_i[15:0],
                                               pstrb_i[1:0]); // [RQ6]
        end
    end

    // ----------------------------------------------------------------
    // Per-setup decode and pacing
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_SETUPS; g++) begin : gen_setup
            setup_cfg_if cfg_bus ();

            setup_decode u_decode (
                .ref_clk_i(ref_clk_i),
                .reset_i(reset_i),
                .cfg_i(cfg_reg[g]),
                .cfg_o(cfg_bus)
            );

            decimation_pacer u_pacer (
                .ref_clk_i(ref_clk_i),
                .reset_i(reset_i),
                .modulator_tick_i(modulator_tick_i),
                .cfg(cfg_bus)
            );

            assign direct_map_o[g] = cfg_bus.direct_map;
            assign decimation_o[g] = cfg_bus.decimation;
            assign order_sinc3_o[g] = cfg_bus.order_sinc3;
            assign rate_code_o[g] = cfg_bus.rate_code;
            assign rate_valid_o[g] = cfg_bus.rate_valid;
            assign post_active_o[g] = cfg_bus.post_active;
            assign post_code_o[g] = cfg_bus.post_code;
            assign result_strobe_o[g] = cfg_bus.result_strobe;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_rate_select_follow: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ1]
        !cfg_reg[0][MAP_BIT] |=> rate_code_o[0] == $past(cfg_reg[0][RATE_HI:0]) &&
            rate_valid_o[0] == ($past(cfg_reg[0][RATE_HI:0]) <= RATE_CODE_SLOWEST))
        else $error("setup 2 rate code not carried to output");

    a_order_default_sinc5: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ3]
        !cfg_reg[1][MAP_BIT] && cfg_reg[1][ORDER_HI:ORDER_LO] == ORDER_SINC5_SINC1
            |=> !order_sinc3_o[1])
        else $error("order 00 did not select sinc5 plus sinc1");

    a_direct_map_override: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ4]
        cfg_reg[1][MAP_BIT] |=> direct_map_o[1] && order_sinc3_o[1] && !post_active_o[1] &&
            !rate_valid_o[1] && decimation_o[1] == $past(cfg_reg[1][DECIM_HI:0]))
        else $error("direct mapping did not override other fields");

    a_post_needs_sinc5: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ7]
        post_active_o[1] |-> $past(cfg_reg[1][POST_EN_BIT]) && !$past(cfg_reg[1][MAP_BIT]) &&
            $past(cfg_reg[1][ORDER_HI:ORDER_LO]) == ORDER_SINC5_SINC1)
        else $error("post filter active without sinc5 plus sinc1 order");

    a_post_code_select: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ8]
        !cfg_reg[1][MAP_BIT] |=> post_code_o[1] == $past(cfg_reg[1][POST_SEL_HI:POST_SEL_LO]) &&
            (!post_active_o[1] || post_code_listed(post_code_o[1])))
        else $error("post filter select not carried or not listed");

    a_reserved_read_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ6]
        commit && !pwrite_i && req_dec == 2'b11
            |-> prdata_o[31:16] == 16'h0000 &&
                (prdata_o[15:0] & ~FILTER_CONFIG_WRITE_MASK) == 16'h0000)
        else $error("reserved bits of setup 3 read nonzero");

    a_write_lands_masked: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ6]
        commit && pwrite_i && req_dec == 2'b11 && pstrb_i[1:0] == 2'b11
            |=> cfg_reg[1] == ($past(pwdata_i[15:0]) & FILTER_CONFIG_WRITE_MASK))
        else $error("setup 3 write not stored with reserved bits cleared");
endmodule
`default_nettype wire

// [verif/filter_setup_config_regs_tb.sv]
`default_nettype none
module filter_setup_config_regs_tb
    import filter_setup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic tick = 1'b0;
    logic tick_en = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_SETUPS-1:0] dmap, osinc3, rvalid, pact, strobe;
    logic [NUM_SETUPS-1:0][14:0] decim;
    logic [NUM_SETUPS-1:0][4:0] rcode;
    logic [NUM_SETUPS-1:0][2:0] pcode;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int tcnt = 0;
    logic [31:0] seed = 32'h00014506;
    logic [15:0] sh [NUM_SETUPS] = '{16'h0000, 16'h0000};
    int per [NUM_SETUPS] = '{0, 0};
    int last [NUM_SETUPS] = '{0, 0};
    int nstr [NUM_SETUPS] = '{0, 0};
    bit seen [NUM_SETUPS] = '{0, 0};

    always #2.5 clk = ~clk;

    filter_setup_config_regs u_filter_setup_config_regs (
        .ref_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .modulator_tick_i(tick), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .direct_map_o(dmap), .decimation_o(decim),
        .order_sinc3_o(osinc3), .rate_code_o(rcode), .rate_valid_o(rvalid),
        .post_active_o(pact), .post_code_o(pcode), .result_strobe_o(strobe)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic listed(input logic [2:0] c);
        return c == 3'b010 || c == 3'b011 || c == 3'b101 || c == 3'b110;
    endfunction

    function automatic logic [11:0] adr(input int s);
        return (s == 0) ? 12'h0a8 : 12'h0ac;
    endfunction

    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] v, input logic [31:0] e);
        cmp_count++;
        if (v !== e) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, v, e);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] st, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            #1;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) bad_count++;
        rd = prdata;
        er = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input int s, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] rd;
        logic er;
        logic [15:0] n;
        apb(1'b1, adr(s), d, st, rd, er);
        check({31'h0, er}, 32'h0);
        n = sh[s];
        if (st[0]) n[7:0] = d[7:0];
        if (st[1]) n[15:8] = d[15:8];
        sh[s] = n & 16'h8f7f;
    endtask

    task automatic rd_chk(input int s);
        logic [31:0] rd;
        logic er;
        apb(1'b0, adr(s), rnd(), 4'h0, rd, er);
        check(rd, {16'h0, sh[s]});
        check({31'h0, er}, 32'h0);
    endtask

    task automatic dec_chk(input int s);
        logic [15:0] c;
        logic m;
        c = sh[s];
        m = c[15];
        @(posedge clk);
        #1;
        check(dmap[s], m);
        check(decim[s], m ? c[14:0] : 15'h0);
        check(osinc3[s], m || c[6:5] == 2'b11);
        check(rcode[s], m ? 5'h0 : c[4:0]);
        check(rvalid[s], !m && c[4:0] <= 5'h14);
        check(pcode[s], m ? 3'h0 : c[10:8]);
        check(pact[s], c[11] && c[6:5] == 2'b00 && !m && listed(c[10:8]));
    endtask

    // ----------------------------------------------------------------
    // Ticks, strobe spacing, timeout
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        tick <= tick_en & (^rnd());
    end

    always @(posedge clk) begin
        for (int s = 0; s < NUM_SETUPS; s++) begin
            if (strobe[s] === 1'b1) begin
                if (per[s] == 0) check(32'h1, 32'h0);
                else if (seen[s]) check(tcnt - last[s], 32 * per[s]);
                last[s] = tcnt;
                seen[s] = 1'b1;
                nstr[s]++;
            end
        end
        if (tick === 1'b1) tcnt++;
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] d, rd;
        logic er;
        int s;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < NUM_SETUPS; k++) begin
            rd_chk(k);
            dec_chk(k);
        end
        for (int i = 0; i < 32; i++) begin
            wr(0, (i % 4) << 5 | i, 4'h3);
            dec_chk(0);
        end
        for (int i = 0; i < 32; i++) begin
            wr(1, (i / 8 % 2) << 11 | (i % 8) << 8 | (i / 16) * 32'h60, 4'h3);
            dec_chk(1);
        end
        for (int i = 0; i < 60; i++) begin
            s = rnd() % 2;
            d = rnd();
            if (d[15] || sh[s][15]) d = d & ~32'h00007080;
            if (d[11] && !listed(d[10:8])) d[11] = 1'b0;
            wr(s, d, rnd() % 16);
            dec_chk(s);
            rd_chk(s);
        end
        foreach (d[i]) if (i < 3) begin
            apb(1'b1, (i == 0) ? 12'h000 : (i == 1) ? 12'h0a4 : 12'h0b0, 32'hffff, 4'hf, rd, er);
            check({31'h0, er}, 32'h1);
            apb(1'b0, (i == 0) ? 12'h000 : (i == 1) ? 12'h0a4 : 12'h0b0, 32'h0, 4'h0, rd, er);
            check({31'h0, er}, 32'h1);
            check(rd, 32'h0);
        end
        rd_chk(0);
        rd_chk(1);
        wr(0, 32'h0, 4'h3);
        wr(1, 32'h0, 4'h3);
        tick_en <= 1'b1;
        for (int n = 1; n <= 4; n++) begin
            s = n % 2;
            per[s] = n;
            seen[s] = 1'b0;
            nstr[s] = 0;
            wr(s, 32'h8000 | n, 4'h3);
            dec_chk(s);
            repeat (260 * n + 100) @(posedge clk);
            check({31'h0, nstr[s] >= 3}, 32'h1);
            wr(s, 32'h0, 4'h3);
            repeat (3) @(posedge clk);
            per[s] = 0;
        end
        wr(1, 32'h8000, 4'h3);
        repeat (300) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        sh[0] = 16'h0;
        sh[1] = 16'h0;
        @(posedge clk);
        rd_chk(0);
        rd_chk(1);
        end_sim();
    end
endmodule
`default_nettype wire
